/* pkg/iafs_pkg.sv */
// Constants shared by the in-application flash sequencer
package iafs_pkg;

    // Special function register addresses
    localparam logic [7:0] IAFS_SFR_CTRL    = 8'he4;
    localparam logic [7:0] IAFS_SFR_ADR_LO  = 8'he5;
    localparam logic [7:0] IAFS_SFR_ADR_HI  = 8'he6;

    // Reset values
    localparam logic [7:0] IAFS_ADR_LO_RST  = 8'h00;
    localparam logic [7:0] IAFS_ADR_HI_RST  = 8'h00;
    localparam logic [3:0] IAFS_CTRL_RST    = 4'h0;

    // Control register field positions
    localparam int IAFS_BIT_ENABLE   = 7;
    localparam int IAFS_BIT_PROGRAM  = 6;
    localparam int IAFS_BIT_READBACK = 5;
    localparam int IAFS_BIT_ERASE    = 4;

    // Command patterns
    localparam logic [7:0] IAFS_CMD_ERASE    = 8'h90;
    localparam logic [7:0] IAFS_CMD_PROGRAM  = 8'hc0;
    localparam logic [7:0] IAFS_CMD_READBACK = 8'ha0;

    // Staging buffer and flash geometry
    localparam logic [8:0] IAFS_BUF_BASE    = 9'h100;
    localparam int         IAFS_BUF_BYTES   = 64;
    localparam int         IAFS_IDX_W       = 6;
    localparam int         IAFS_FLASH_AW    = 14;
    localparam int         IAFS_AUX_AW      = 9;

    // Sequencer states
    typedef enum logic [3:0] {
        IAFS_IDLE    = 4'h0,
        IAFS_E_WAIT  = 4'h1,
        IAFS_P_FETCH = 4'h2,
        IAFS_P_LOAD  = 4'h3,
        IAFS_P_WAIT  = 4'h4,
        IAFS_P_STEP  = 4'h5,
        IAFS_R_FETCH = 4'h6,
        IAFS_R_LOAD  = 4'h7,
        IAFS_R_STORE = 4'h8,
        IAFS_R_STEP  = 4'h9
    } iafs_state_t;

endpackage

/* rtl/iafs_byte_count.sv */
// Byte index counter for 64-byte staging transfers
`timescale 1ns/1ps
`default_nettype none
module iafs_byte_count (
    input  wire logic                            clk_sys,
    input  wire logic                            rst_n,
    input  wire logic                            clear,
    input  wire logic                            step,
    output logic [iafs_pkg::IAFS_IDX_W-1:0]      idx,
    output logic                                 last
);
    import iafs_pkg::*;

    typedef struct packed {
        logic [IAFS_IDX_W-1:0] idx;
        logic                  last;
    } iafs_cnt_t;

    iafs_cnt_t cnt_ff;
    iafs_cnt_t nxt_cnt;

    // Clear wins over step; last marks index 63
    always_comb begin
        nxt_cnt = cnt_ff;
        if (clear) begin
            nxt_cnt.idx = '0;
        end else if (step) begin
            nxt_cnt.idx = cnt_ff.idx + 1'b1;
        end
        nxt_cnt.last = (nxt_cnt.idx == IAFS_IDX_W'(IAFS_BUF_BYTES - 1));
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign idx  = cnt_ff.idx;
    assign last = cnt_ff.last;
endmodule
`default_nettype wire

/* rtl/iafs_top.sv */
// In-application flash sequencer: SFRs, command decode, transfer engine
`timescale 1ns/1ps
`default_nettype none
module iafs_top (
    input  wire logic                               clk_sys,
    input  wire logic                               rst_n,
    input  wire logic [7:0]                         sfr_addr,
    input  wire logic                               sfr_wr,
    input  wire logic                               sfr_rd,
    input  wire logic [7:0]                         sfr_wdata,
    output logic [7:0]                              sfr_rdata,
    output logic                                    cpu_stall,
    output logic [iafs_pkg::IAFS_AUX_AW-1:0]        aux_addr,
    output logic                                    aux_rd,
    output logic                                    aux_wr,
    output logic [7:0]                              aux_wdata,
    input  wire logic [7:0]                         aux_rdata,
    output logic [iafs_pkg::IAFS_FLASH_AW-1:0]      flash_addr,
    output logic                                    flash_rd,
    output logic                                    flash_prog,
    output logic                                    flash_erase,
    output logic [7:0]                              flash_wdata,
    input  wire logic [7:0]                         flash_rdata,
    input  wire logic                               flash_done
);
    import iafs_pkg::*;

    typedef struct packed {
        iafs_state_t              st;
        logic [7:4]               ctrl;
        logic [7:0]               adr_lo;
        logic [7:0]               adr_hi;
        logic [7:0]               rdata;
        logic                     stall;
        logic [IAFS_FLASH_AW-1:0] fl_addr;
        logic                     fl_rd;
        logic                     fl_prog;
        logic                     fl_erase;
        logic [7:0]               fl_wdata;
        logic [IAFS_AUX_AW-1:0]   ax_addr;
        logic                     ax_rd;
        logic                     ax_wr;
        logic [7:0]               ax_wdata;
    } iafs_regs_t;

    iafs_regs_t               r_ff;
    iafs_regs_t               nxt_r;
    logic [IAFS_IDX_W-1:0]    idx;
    logic                     last;
    logic                     cnt_clear;
    logic                     cnt_step;

    // Flash byte address: start plus byte index
    function automatic logic [IAFS_FLASH_AW-1:0] flash_at(
        input logic [7:0]            hi,
        input logic [7:0]            lo,
        input logic [IAFS_IDX_W-1:0] i
    );
        logic [15:0] full;
        full = {hi, lo} + {10'h000, i};
        return full[IAFS_FLASH_AW-1:0];
    endfunction

    // Staging buffer slot address
    function automatic logic [IAFS_AUX_AW-1:0] aux_slot(input logic [IAFS_IDX_W-1:0] i);
        return IAFS_BUF_BASE + {3'h0, i};
    endfunction

    iafs_byte_count u_count (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clear   (cnt_clear),
        .step    (cnt_step),
        .idx     (idx),
        .last    (last)
    );

    // Sequencer, register file and strobe generation
    always_comb begin
        nxt_r       = r_ff;
        nxt_r.fl_rd    = 1'b0;
        nxt_r.fl_prog  = 1'b0;
        nxt_r.fl_erase = 1'b0;
        nxt_r.ax_rd    = 1'b0;
        nxt_r.ax_wr    = 1'b0;
        cnt_clear   = 1'b0;
        cnt_step    = 1'b0;
        // Registered read data, unmapped reads return zero
        if (sfr_rd) begin
            case (sfr_addr)
                // control bits readable, low nibble zero
                IAFS_SFR_CTRL:   nxt_r.rdata = {r_ff.ctrl, 4'h0};
                IAFS_SFR_ADR_LO: nxt_r.rdata = r_ff.adr_lo;
                IAFS_SFR_ADR_HI: nxt_r.rdata = r_ff.adr_hi;
                default:         nxt_r.rdata = 8'h00;
            endcase
        end
        case (r_ff.st)
            IAFS_IDLE: begin
                if (sfr_wr) begin
                    case (sfr_addr)
                        IAFS_SFR_ADR_LO: nxt_r.adr_lo = sfr_wdata;
                        IAFS_SFR_ADR_HI: nxt_r.adr_hi = sfr_wdata;
                        IAFS_SFR_CTRL: begin
                            nxt_r.ctrl = sfr_wdata[7:4];
                            cnt_clear  = 1'b1;
                            case (sfr_wdata)
                                IAFS_CMD_ERASE: begin
                                    nxt_r.st       = IAFS_E_WAIT;
                                    nxt_r.stall    = 1'b1;
                                    nxt_r.fl_erase = 1'b1;
                                    nxt_r.fl_addr  = flash_at(r_ff.adr_hi, r_ff.adr_lo, '0);
                                end
                                IAFS_CMD_PROGRAM: begin
                                    nxt_r.st      = IAFS_P_FETCH;
                                    nxt_r.stall   = 1'b1;
                                    nxt_r.ax_rd   = 1'b1;
                                    nxt_r.ax_addr = aux_slot('0);
                                end
                                IAFS_CMD_READBACK: begin
                                    nxt_r.st      = IAFS_R_FETCH;
                                    nxt_r.stall   = 1'b1;
                                    nxt_r.fl_rd   = 1'b1;
                                    nxt_r.fl_addr = flash_at(r_ff.adr_hi, r_ff.adr_lo, '0);
                                end
                                default: nxt_r.st = IAFS_IDLE;
                            endcase
                        end
                        default: nxt_r.st = IAFS_IDLE;
                    endcase
                end
            end
            IAFS_E_WAIT: begin
                if (flash_done) begin
                    nxt_r.st = IAFS_IDLE;
                end
            end
            IAFS_P_FETCH: nxt_r.st = IAFS_P_LOAD;
            IAFS_P_LOAD: begin
                // program strobe only inside a command
                nxt_r.st       = IAFS_P_WAIT;
                nxt_r.fl_prog  = 1'b1;
                nxt_r.fl_wdata = aux_rdata;
                nxt_r.fl_addr  = flash_at(r_ff.adr_hi, r_ff.adr_lo, idx);
            end
            IAFS_P_WAIT: begin
                if (flash_done) begin
                    nxt_r.st = last ? IAFS_IDLE : IAFS_P_STEP;
                    cnt_step = !last;
                end
            end
            IAFS_P_STEP: begin
                nxt_r.st      = IAFS_P_FETCH;
                nxt_r.ax_rd   = 1'b1;
                nxt_r.ax_addr = aux_slot(idx);
            end
            IAFS_R_FETCH: nxt_r.st = IAFS_R_LOAD;
            IAFS_R_LOAD: begin
                // flash byte lands in buffer slot
                nxt_r.st       = IAFS_R_STORE;
                nxt_r.ax_wr    = 1'b1;
                nxt_r.ax_wdata = flash_rdata;
                nxt_r.ax_addr  = aux_slot(idx);
            end
            IAFS_R_STORE: begin
                nxt_r.st = last ? IAFS_IDLE : IAFS_R_STEP;
                cnt_step = !last;
            end
            IAFS_R_STEP: begin
                nxt_r.st      = IAFS_R_FETCH;
                nxt_r.fl_rd   = 1'b1;
                nxt_r.fl_addr = flash_at(r_ff.adr_hi, r_ff.adr_lo, idx);
            end
            default: nxt_r.st = IAFS_IDLE;
        endcase
        // completion releases CPU and clears command
        if (r_ff.st != IAFS_IDLE && nxt_r.st == IAFS_IDLE) begin
            nxt_r.stall = 1'b0;
            nxt_r.ctrl  = IAFS_CTRL_RST;
            cnt_clear   = 1'b1;
        end
    end

    // State register, constants only under reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r_ff        <= '0;
            r_ff.st     <= IAFS_IDLE;
            r_ff.ctrl   <= IAFS_CTRL_RST;
            r_ff.adr_lo <= IAFS_ADR_LO_RST;
            r_ff.adr_hi <= IAFS_ADR_HI_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign sfr_rdata   = r_ff.rdata;
    assign cpu_stall   = r_ff.stall;
    assign aux_addr    = r_ff.ax_addr;
    assign aux_rd      = r_ff.ax_rd;
    assign aux_wr      = r_ff.ax_wr;
    assign aux_wdata   = r_ff.ax_wdata;
    assign flash_addr  = r_ff.fl_addr;
    assign flash_rd    = r_ff.fl_rd;
    assign flash_prog  = r_ff.fl_prog;
    assign flash_erase = r_ff.fl_erase;
    assign flash_wdata = r_ff.fl_wdata;

    // Assertion helpers
    logic        cmd_ok;
    logic [15:0] start_adr;
    assign cmd_ok    = sfr_wr && sfr_addr == IAFS_SFR_CTRL && r_ff.st == IAFS_IDLE;
    assign start_adr = {r_ff.adr_hi, r_ff.adr_lo};

    sequence s_prog_byte;
        aux_rd ##2 flash_prog;
    endsequence

    sequence s_read_byte;
        flash_rd ##2 aux_wr;
    endsequence

    a_buf_window: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (aux_rd || aux_wr) |-> (aux_addr >= IAFS_BUF_BASE
            && aux_addr < IAFS_BUF_BASE + 9'(IAFS_BUF_BYTES)))
        else $error("buffer access outside staging window");

    a_start_concat: assert property (@(posedge clk_sys) disable iff (!rst_n)
        flash_erase |-> flash_addr == start_adr[IAFS_FLASH_AW-1:0])
        else $error("erase address not high/low concatenation");

    a_erase_launch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd_ok && sfr_wdata == IAFS_CMD_ERASE |=> flash_erase && cpu_stall)
        else $error("erase command did not start erase");

    a_prog_launch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd_ok && sfr_wdata == IAFS_CMD_PROGRAM |=> s_prog_byte)
        else $error("program command did not fetch then program");

    a_read_launch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd_ok && sfr_wdata == IAFS_CMD_READBACK |=> s_read_byte)
        else $error("readback command did not read then store");

    a_flash_guard: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (flash_prog || flash_erase) |-> cpu_stall)
        else $error("flash modified outside a command");

    a_addr_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sfr_wr && sfr_addr == IAFS_SFR_ADR_HI && r_ff.st == IAFS_IDLE
        |=> r_ff.adr_hi == $past(sfr_wdata))
        else $error("high address byte not stored");

    a_ctrl_nibble: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sfr_rd && sfr_addr == IAFS_SFR_CTRL |=> sfr_rdata[3:0] == 4'h0
            && sfr_rdata[7:4] == $past(r_ff.ctrl))
        else $error("control read value wrong");

    a_bad_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cmd_ok && sfr_wdata != IAFS_CMD_ERASE && sfr_wdata != IAFS_CMD_PROGRAM
            && sfr_wdata != IAFS_CMD_READBACK |=> !cpu_stall ##1 !cpu_stall)
        else $error("unknown pattern started work");

    a_stall_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(cpu_stall) |-> $past(r_ff.st) != IAFS_IDLE && r_ff.st == IAFS_IDLE)
        else $error("stall dropped before completion");
endmodule
`default_nettype wire

/* verification/iafs_mem_model.sv */
// Behavioural flash array and auxiliary RAM facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module iafs_mem_model (
    input  wire logic        clk_sys,
    input  wire logic [3:0]  dly,
    input  wire logic [8:0]  aux_addr,
    input  wire logic        aux_rd,
    input  wire logic        aux_wr,
    input  wire logic [7:0]  aux_wdata,
    output logic      [7:0]  aux_rdata,
    input  wire logic [13:0] flash_addr,
    input  wire logic        flash_rd,
    input  wire logic        flash_prog,
    input  wire logic        flash_erase,
    input  wire logic [7:0]  flash_wdata,
    output logic      [7:0]  flash_rdata,
    output logic             flash_done
);
    logic [7:0] aux [512];
    logic [7:0] flash [16384];
    logic [3:0] cnt  = 4'h0;
    logic       pend = 1'b0;

    // Blank array, cleared buffer
    initial begin
        for (int i = 0; i < 16384; i++) flash[i] = 8'hff;
        for (int i = 0; i < 512; i++) aux[i] = 8'h00;
    end

    // Sync RAM; stale data inverted when not read
    always @(posedge clk_sys) begin
        aux_rdata <= aux_rd ? aux[aux_addr] : ~aux_rdata;
        if (aux_wr) aux[aux_addr] <= aux_wdata;
    end

    // array keeps bytes, erase clears aligned block
    always @(posedge clk_sys) begin
        flash_rdata <= flash_rd ? flash[flash_addr] : ~flash_rdata;
        if (flash_prog) flash[flash_addr] <= flash_wdata;
        if (flash_erase) begin
            for (int i = 0; i < 512; i++) flash[{flash_addr[13:9], 9'(i)}] <= 8'hff;
        end
    end

    // Done pulse after dly further cycles
    always @(posedge clk_sys) begin
        flash_done <= 1'b0;
        if (flash_prog || flash_erase) begin
            cnt <= dly;
            pend <= 1'b1;
        end else if (pend && cnt == 4'h0) begin
            flash_done <= 1'b1;
            pend <= 1'b0;
        end else if (pend) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule
`default_nettype wire

/* verification/in_app_flash_sequencer_tb.sv */
// Self-checking bench for the in-application flash sequencer
`timescale 1ns/1ps
`default_nettype none
module in_app_flash_sequencer_tb;
    import iafs_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, aux_wdata, aux_rdata;
    logic [7:0] flash_wdata, flash_rdata, v;
    logic [8:0] aux_addr;
    logic [13:0] flash_addr;
    logic cpu_stall, aux_rd, aux_wr, flash_rd, flash_prog, flash_erase, flash_done;
    logic [3:0] dly = 4'h0;
    logic [7:0] exp_f [16384];
    logic [7:0] exp_a [512];
    logic [7:0] ops [6];
    logic [15:0] a;
    int error_cnt = 0, n_checks = 0, seed = 32'hfa8e4afd;

    iafs_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cpu_stall(cpu_stall),
        .aux_addr(aux_addr), .aux_rd(aux_rd), .aux_wr(aux_wr), .aux_wdata(aux_wdata),
        .aux_rdata(aux_rdata), .flash_addr(flash_addr), .flash_rd(flash_rd),
        .flash_prog(flash_prog), .flash_erase(flash_erase), .flash_wdata(flash_wdata),
        .flash_rdata(flash_rdata), .flash_done(flash_done));
    iafs_mem_model u_mem (.clk_sys(clk_sys), .dly(dly), .aux_addr(aux_addr), .aux_rd(aux_rd),
        .aux_wr(aux_wr), .aux_wdata(aux_wdata), .aux_rdata(aux_rdata),
        .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_prog(flash_prog),
        .flash_erase(flash_erase), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
        .flash_done(flash_done));

    // Free-running clock
    always #5 clk_sys = ~clk_sys;

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk_sys); #1;
        sfr_addr = ad;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk_sys); #1;
        sfr_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clk_sys); #1;
        sfr_addr = ad;
        sfr_rd = 1'b1;
        @(posedge clk_sys); #1;
        sfr_rd = 1'b0;
        chk("sfr_rdata", sfr_rdata, e);
    endtask

    // Starts one command, waits for it, updates and compares the model
    task automatic run(input logic [7:0] op, input logic [15:0] ad, input logic [3:0] d);
        int n;
        logic [13:0] b;
        b = ad[13:0];
        dly = d;
        wr(IAFS_SFR_ADR_LO, ad[7:0]);
        wr(IAFS_SFR_ADR_HI, ad[15:8]);
        wr(IAFS_SFR_CTRL, op);
        chk("cpu_stall", cpu_stall, 1);
        if (op == IAFS_CMD_PROGRAM) wr(IAFS_SFR_ADR_LO, ~ad[7:0]);
        n = 0;
        while (cpu_stall !== 1'b0 && n < 3000) begin
            @(posedge clk_sys); #1;
            n++;
        end
        chk("stall_end", n < 3000, 1);
        for (int i = 0; i < 512 && op == IAFS_CMD_ERASE; i++) exp_f[{b[13:9], 9'(i)}] = 8'hff;
        for (int i = 0; i < 64 && op == IAFS_CMD_PROGRAM; i++) exp_f[14'(b + i)] = exp_a[256 + i];
        for (int i = 0; i < 64 && op == IAFS_CMD_READBACK; i++) exp_a[256 + i] = exp_f[14'(b + i)];
        rd(IAFS_SFR_CTRL, 8'h00);
        rd(IAFS_SFR_ADR_LO, ad[7:0]);
        for (int i = 0; i < 16384; i++) chk("flash", u_mem.flash[i], exp_f[i]);
        for (int i = 0; i < 512; i++) chk("aux", u_mem.aux[i], exp_a[i]);
        $display("test op %h at %h done", op, ad);
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Watchdog against a hung sequencer
    initial begin
        repeat (60000) @(posedge clk_sys);
        error_cnt++;
        wrap_up();
    end

    initial begin
        ops = '{IAFS_CMD_PROGRAM, IAFS_CMD_READBACK, IAFS_CMD_ERASE, IAFS_CMD_READBACK,
                IAFS_CMD_PROGRAM, IAFS_CMD_READBACK};
        for (int i = 0; i < 16384; i++) exp_f[i] = 8'hff;
        for (int i = 0; i < 512; i++) exp_a[i] = 8'h00;
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        rd(IAFS_SFR_CTRL, 8'h00);
        rd(IAFS_SFR_ADR_LO, 8'h00);
        rd(IAFS_SFR_ADR_HI, 8'h00);
        rd(8'he7, 8'h00);
        $display("test reset values done");
        // Random non-command control values start nothing
        for (int k = 0; k < 6; k++) begin
            v = 8'($random(seed));
            if (v == IAFS_CMD_ERASE || v == IAFS_CMD_PROGRAM || v == IAFS_CMD_READBACK) v ^= 8'h01;
            if (k == 0) v = 8'h9f;
            wr(IAFS_SFR_CTRL, v);
            chk("cpu_stall", cpu_stall, 0);
            rd(IAFS_SFR_CTRL, {v[7:4], 4'h0});
            wr(IAFS_SFR_ADR_HI, ~v);
            rd(IAFS_SFR_ADR_HI, ~v);
        end
        $display("test register access done");
        a = 16'($random(seed));
        for (int k = 0; k < 6; k++) begin
            for (int i = 0; i < 64; i++) begin
                exp_a[256 + i] = 8'($random(seed));
                u_mem.aux[256 + i] = exp_a[256 + i];
            end
            run(ops[k], (k < 4) ? a : 16'hffe0, 4'(k * 2));
        end
        wrap_up();
    end
endmodule
`default_nettype wire
